// *** rtl/ats_trigger_select.v ***
/*
 * Trigger select register for analog inputs 4 to 7 with an AXI4-Lite
 * slave and one registered conversion-start output per input.
 * Assumes event sources are on clk_sys (pulses or levels) and the
 * scan trigger is already resolved from its own source field.
 */
// Overview of operation
// - Four 5-bit fields at 28:24, 20:16, 12:8, 4:0 for inputs 7..4.
// - Code 00001 edge software trigger; 00010 level software trigger.
// - 00100 external interrupt zero, 00101 timer one, 00111 timer five.
// - 01000/01001/01010 compares, 01011/01100 comparators, 01101 up reserved.
// - Bits 31:29, 23:21, 15:13, 7:5 read back as zero.
`timescale 1ns/10ps
`default_nettype none
`include "ats_map.vh"

module ats_trigger_select #(
    parameter N = 4
) (
    // Clock and reset
    input  wire         clk_sys,
    input  wire         rst_b,
    // AXI4-Lite write address
    input  wire [7:0]   s_axi_awaddr,
    input  wire         s_axi_awvalid,
    output reg          s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0]  s_axi_wdata,
    input  wire [3:0]   s_axi_wstrb,
    input  wire         s_axi_wvalid,
    output reg          s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]   s_axi_bresp,
    output reg          s_axi_bvalid,
    input  wire         s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]   s_axi_araddr,
    input  wire         s_axi_arvalid,
    output reg          s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0]  s_axi_rdata,
    output reg  [1:0]   s_axi_rresp,
    output reg          s_axi_rvalid,
    input  wire         s_axi_rready,
    // Trigger events, same clock domain
    input  wire         edge_soft,
    input  wire         level_soft,
    input  wire         scan_trigger,
    input  wire         ext_external_interrupt_zero,
    input  wire         timer_one,
    input  wire         timer_five,
    input  wire         oc_one,
    input  wire         oc_three,
    input  wire         oc_five,
    input  wire         cmp_one,
    input  wire         cmp_two,
    // Conversion starts, bit 0 is input 4
    output reg  [N-1:0] conv_start
);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    reg  [31:0]  trig_sel;
    reg  [7:0]   aw_addr;
    reg          aw_held;
    reg  [31:0]  w_data;
    reg  [3:0]   w_strb;
    reg          w_held;
    wire [N-1:0] next_conv_start;
    wire [31:0]  merged;
    wire         do_write;
    wire         wr_sel_hit;
    wire         wr_stat_hit;
    wire         rd_sel_hit;
    wire         rd_stat_hit;
    wire [31:0]  sel_view;
    wire [31:0]  stat_view;

    // ****************************************************************
    // Address decode and read views
    // ****************************************************************
    // Shared compares keep the write and read maps from drifting apart
    assign wr_sel_hit  = (aw_addr == `ATS_TRIG_SEL_OFFSET);
    assign wr_stat_hit = (aw_addr == `ATS_STATUS_OFFSET);
    assign rd_sel_hit  = (s_axi_araddr == `ATS_TRIG_SEL_OFFSET);
    assign rd_stat_hit = (s_axi_araddr == `ATS_STATUS_OFFSET);
    // Gaps between fields read as zero whatever the flops hold
    assign sel_view    = trig_sel & `ATS_FIELD_MASK;
    // Live view, so a read sees the starts of the previous cycle
    assign stat_view   = {{(32-N){1'b0}}, conv_start};

    // ****************************************************************
    // Per-input source selection
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < N; gi = gi + 1) begin : g_in
            ats_source_mux u_mux (
                .sel          (trig_sel[gi*`ATS_FIELD_STRIDE +: `ATS_FIELD_W]),
                .edge_soft    (edge_soft),
                .level_soft   (level_soft),
                .scan_trigger (scan_trigger),
                .ext_external_interrupt_zero     (ext_external_interrupt_zero),
                .timer_one    (timer_one),
                .timer_five   (timer_five),
                .oc_one       (oc_one),
                .oc_three     (oc_three),
                .oc_five      (oc_five),
                .cmp_one      (cmp_one),
                .cmp_two      (cmp_two),
                .trig         (next_conv_start[gi])
            );
        end
    endgenerate

    // Start outputs registered so they come straight from flops
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            conv_start <= {N{1'b0}};
        end else begin
            conv_start <= next_conv_start;
        end
    end

    // ****************************************************************
    // Write channel: address and data taken in either order
    // ****************************************************************
    // Commit only once both halves are held and the last response is gone
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    // Byte strobes merged; unimplemented bits masked so they stay zero
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb = gb + 1) begin : g_lane
            assign merged[gb*8 +: 8] = w_strb[gb] ? w_data[gb*8 +: 8] : trig_sel[gb*8 +: 8];
        end
    endgenerate

    // Capture address and data, then commit and respond on one edge
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            trig_sel      <= `ATS_TRIG_SEL_RESET;
            aw_addr       <= 8'h00;
            aw_held       <= 1'b0;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ATS_RESP_OKAY;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            // No new address or data while a response waits to be taken
            if (s_axi_awvalid && !aw_held && !s_axi_awready && !s_axi_bvalid) begin
                aw_addr       <= s_axi_awaddr;
                aw_held       <= 1'b1;
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && !w_held && !s_axi_wready && !s_axi_bvalid) begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                w_held       <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            // Commit and respond on one edge; the response stands until taken
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wr_sel_hit) begin
                    trig_sel    <= merged & `ATS_FIELD_MASK;
                    s_axi_bresp <= `ATS_RESP_OKAY;
                end else if (wr_stat_hit) begin
                    s_axi_bresp <= `ATS_RESP_OKAY; // Status is read-only
                end else begin
                    s_axi_bresp <= `ATS_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Read channel
    // ****************************************************************
    // One read in flight; address accepted only when no data pending
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `ATS_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `ATS_RESP_OKAY;
                if (rd_sel_hit) begin
                    s_axi_rdata <= sel_view;
                end else if (rd_stat_hit) begin
                    // Live view of which inputs started a conversion
                    s_axi_rdata <= stat_view;
                end else begin
                    // Unmapped reads answer with an error and zero data
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `ATS_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// *** rtl/ats_map.vh ***
/*
 * Register map, field layout, trigger codes and reset values of the
 * converter trigger select block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ATS_MAP_VH
`define ATS_MAP_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define ATS_TRIG_SEL_OFFSET     8'h00
`define ATS_STATUS_OFFSET       8'h04

// ****************************************************************
// Field layout
// ****************************************************************
`define ATS_FIELD_W             5
`define ATS_FIELD_STRIDE        8
`define ATS_NUM_INPUTS          4
`define ATS_FIELD_MASK          32'h1F1F1F1F
`define ATS_TRIG_SEL_RESET      32'h00000000

// ****************************************************************
// Trigger codes
// ****************************************************************
`define ATS_CODE_NONE           5'h00
`define ATS_CODE_EDGE_SOFT      5'h01
`define ATS_CODE_LEVEL_SOFT     5'h02
`define ATS_CODE_SCAN           5'h03
`define ATS_CODE_EXT_EXTERNAL_INTERRUPT_ZERO       5'h04
`define ATS_CODE_TIMER_ONE      5'h05
`define ATS_CODE_TIMER_FIVE     5'h07
`define ATS_CODE_OC_ONE         5'h08
`define ATS_CODE_OC_THREE       5'h09
`define ATS_CODE_OC_FIVE        5'h0A
`define ATS_CODE_CMP_ONE        5'h0B
`define ATS_CODE_CMP_TWO        5'h0C

// ****************************************************************
// Bus responses
// ****************************************************************
`define ATS_RESP_OKAY           2'h0
`define ATS_RESP_SLVERR         2'h2

`endif

// *** rtl/ats_source_mux.v ***
/*
 * One input's trigger source multiplexer: maps a 5-bit select code to
 * one trigger event bit.
 * Assumes event inputs are already synchronous to clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ats_map.vh"

module ats_source_mux (
    // Selection
    input  wire [4:0] sel,
    // Event sources, one bit each
    input  wire       edge_soft,
    input  wire       level_soft,
    input  wire       scan_trigger,
    input  wire       ext_external_interrupt_zero,
    input  wire       timer_one,
    input  wire       timer_five,
    input  wire       oc_one,
    input  wire       oc_three,
    input  wire       oc_five,
    input  wire       cmp_one,
    input  wire       cmp_two,
    // Selected event
    output reg        trig
);

    // Decode; unused and reserved codes give no trigger
    always @* begin
        case (sel)
            `ATS_CODE_NONE:       trig = 1'b0;
            `ATS_CODE_EDGE_SOFT:  trig = edge_soft;
            `ATS_CODE_LEVEL_SOFT: trig = level_soft;
            `ATS_CODE_SCAN:       trig = scan_trigger;
            `ATS_CODE_EXT_EXTERNAL_INTERRUPT_ZERO:   trig = ext_external_interrupt_zero;
            `ATS_CODE_TIMER_ONE:  trig = timer_one;
            `ATS_CODE_TIMER_FIVE: trig = timer_five;
            `ATS_CODE_OC_ONE:     trig = oc_one;
            `ATS_CODE_OC_THREE:   trig = oc_three;
            `ATS_CODE_OC_FIVE:    trig = oc_five;
            `ATS_CODE_CMP_ONE:    trig = cmp_one;
            `ATS_CODE_CMP_TWO:    trig = cmp_two;
            default:              trig = 1'b0;
        endcase
    end

endmodule
`default_nettype wire

// *** bench/ats_props.sv ***
/* Port-level checks for the trigger select block.
   Assumes bind onto ats_trigger_select; one clock, synchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module ats_props #(
    parameter N = 4
) (
    // Clock and reset
    input wire logic         clk_sys,
    input wire logic         rst_b,
    // Bus handshakes
    input wire logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready,
    input wire logic         s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [1:0]   s_axi_bresp,
    input wire logic [31:0]  s_axi_rdata,
    // Events and starts
    input wire logic         edge_soft, level_soft, scan_trigger, ext_external_interrupt_zero, timer_one, timer_five,
    input wire logic         oc_one, oc_three, oc_five, cmp_one, cmp_two,
    input wire logic [N-1:0] conv_start
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Any source active in this cycle
    wire any_ev = |{edge_soft, level_soft, scan_trigger, ext_external_interrupt_zero, timer_one, timer_five,
                    oc_one, oc_three, oc_five, cmp_one, cmp_two};
    sequence s_quiet; !any_ev; endsequence
    sequence s_both_taken; s_axi_awready && s_axi_wready; endsequence
    a_quiet_no_start: assert property (s_quiet |=> conv_start == '0)
        else $error("start without an event");
    a_start_has_cause: assert property (conv_start != '0 |-> $past(any_ev))
        else $error("start not caused by an event");
    a_unused_bits_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & ~32'h1F1F1F1F) == 32'h0)
        else $error("unused bits read nonzero");
    a_resp_follows: assert property (s_both_taken |=> s_axi_bvalid)
        else $error("write response late");
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_aw_one_cycle: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("address ready held");
    a_ar_with_data: assert property ($rose(s_axi_arready) |-> s_axi_rvalid)
        else $error("read data not with address ready");
endmodule
bind ats_trigger_select ats_props #(.N(N)) u_props (.clk_sys(clk_sys), .rst_b(rst_b),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_rdata(s_axi_rdata),
    .edge_soft(edge_soft), .level_soft(level_soft), .scan_trigger(scan_trigger), .ext_external_interrupt_zero(ext_external_interrupt_zero),
    .timer_one(timer_one), .timer_five(timer_five), .oc_one(oc_one), .oc_three(oc_three),
    .oc_five(oc_five), .cmp_one(cmp_one), .cmp_two(cmp_two), .conv_start(conv_start));
`default_nettype wire

// *** bench/ats_src_model.sv ***
/* Model of the timers, comparators and software trigger sources.
   Assumes the bench picks one source per cycle; 4'hF fires all, 4'hE none. */
`timescale 1ns/10ps
`default_nettype none
module ats_src_model (
    // Source pick
    input wire logic [3:0] ev_sel,
    // Event lines
    output logic           edge_soft, level_soft, scan_trigger, ext_external_interrupt_zero, timer_one, timer_five,
    output logic           oc_one, oc_three, oc_five, cmp_one, cmp_two
);
    // ****************************************************************
    // Sources
    // ****************************************************************
    // Scan line stands for an already programmed scan source and select
    assign {cmp_two, cmp_one, oc_five, oc_three, oc_one, timer_five, timer_one, ext_external_interrupt_zero,
            scan_trigger, level_soft, edge_soft} = (11'h1 << ev_sel) | {11{ev_sel == 4'hF}};
endmodule
`default_nettype wire

// *** bench/ats_trigger_select_tb.sv ***
/* Self-checking bench for the trigger select block.
   Assumes the design, its map header, the checker and the source model. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
    $display("BAD %0t mismatch %h %h", $time, a, b); end end
module ats_trigger_select_tb;
    // ****************************************************************
    // Signals, clock, design and model
    // ****************************************************************
    logic        clk_sys = 0, rst_b = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic [7:0]  awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, d;
    logic [3:0]  ev_sel = 4'hE, ws = 4'hF;
    logic [1:0]  r;
    wire         awr, wr_y, bv, arr, rv, e0, e1, e2, e3, e4, e5, e6, e7, e8, e9, e10;
    wire  [1:0]  br, rr;
    wire  [31:0] rdt;
    wire  [3:0]  conv_start;
    int          failures = 0, n_checks = 0, i;
    // Rows: code, source pick, expected starts for fields 4 and 5
    logic [12:0] rows [0:13] = '{{5'h01, 4'd0, 4'h3}, {5'h02, 4'd1, 4'h3}, {5'h03, 4'd2, 4'h3},
        {5'h04, 4'd3, 4'h3}, {5'h05, 4'd4, 4'h3}, {5'h07, 4'd5, 4'h3}, {5'h08, 4'd6, 4'h3},
        {5'h09, 4'd7, 4'h3}, {5'h0A, 4'd8, 4'h3}, {5'h0B, 4'd9, 4'h3}, {5'h0C, 4'd10, 4'h3},
        {5'h00, 4'hF, 4'h0}, {5'h06, 4'hF, 4'h0}, {5'h1F, 4'hF, 4'h0}};
    always #5 clk_sys = ~clk_sys;
    ats_trigger_select dut (.clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_y),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .edge_soft(e0), .level_soft(e1), .scan_trigger(e2), .ext_external_interrupt_zero(e3), .timer_one(e4), .timer_five(e5),
        .oc_one(e6), .oc_three(e7), .oc_five(e8), .cmp_one(e9), .cmp_two(e10), .conv_start(conv_start));
    ats_src_model u_src (.ev_sel(ev_sel), .edge_soft(e0), .level_soft(e1), .scan_trigger(e2),
        .ext_external_interrupt_zero(e3), .timer_one(e4), .timer_five(e5), .oc_one(e6), .oc_three(e7), .oc_five(e8),
        .cmp_one(e9), .cmp_two(e10));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task stop_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Address and data offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] v);
        int k;
        @(posedge clk_sys);
        awa <= a; wd <= v; awv <= 1; wv <= 1; bry <= 1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk_sys);
            if (awr) awv <= 0;
            if (wr_y) wv <= 0;
            if (bv === 1'b1) break;
        end
        if (k == 50) begin failures++; stop_test(); end
        r = br; bry <= 0;
    endtask
    task rd(input logic [7:0] a);
        int k;
        @(posedge clk_sys);
        ara <= a; arv <= 1; rry <= 1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk_sys);
            if (arr) arv <= 0;
            if (rv === 1'b1) break;
        end
        if (k == 50) begin failures++; stop_test(); end
        r = rr; d = rdt; rry <= 0;
    endtask
    // One-cycle source pulse; starts are looked at in the cycle after it
    task fire(input logic [3:0] e);
        @(posedge clk_sys); ev_sel <= e;
        @(posedge clk_sys); ev_sel <= 4'hE;
        #1;
    endtask
    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_b <= 1;
        rd(8'h00); `CHK(d, 32'h0)
        for (i = 0; i < 14; i++) begin
            wr(8'h00, {8'hED, 8'hE0, 3'h7, rows[i][12:8], 3'h7, rows[i][12:8]}); `CHK(r, 2'h0)
            rd(8'h00); `CHK(d, {8'h0D, 8'h00, 3'h0, rows[i][12:8], 3'h0, rows[i][12:8]})
            fire(rows[i][7:4]); `CHK(conv_start, rows[i][3:0])
        end
        // Distinct codes per field pin down the positions of the input 7 and input 4 fields
        wr(8'h00, 32'h0C0B0A09);
        fire(4'd10); `CHK(conv_start, 4'h8)
        fire(4'd7); `CHK(conv_start, 4'h1)
        fire(4'hF); `CHK(conv_start, 4'hF)
        rd(8'h10); `CHK({r, d}, {2'h2, 32'h0})
        wr(8'h04, 32'hFFFFFFFF); `CHK(r, 2'h0)
        // Byte strobe: only the input 4 field may change
        ws <= 4'h1;
        wr(8'h00, 32'h1F1F1F01); `CHK(r, 2'h0)
        ws <= 4'hF;
        rd(8'h00); `CHK(d, 32'h0C0B0A01)
        // Status shows the previous cycle's starts while all sources stand
        ev_sel <= 4'hF;
        rd(8'h04); `CHK({r, d}, {2'h0, 32'h0000000F})
        ev_sel <= 4'hE;
        // Reset in mid-run clears the fields
        @(posedge clk_sys); rst_b <= 0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1;
        fire(4'hF); `CHK(conv_start, 4'h0)
        rd(8'h00); `CHK(d, 32'h0)
        rd(8'h04); `CHK({r, d}, {2'h0, 32'h0})
        stop_test();
    end
endmodule
`default_nettype wire
